/* design/iap_pkg.sv */
/*
 * Shared constants for the slave-address and data/command port block:
 * register offsets, field positions, reset values, build options, FIFO sizing.
 * Assumes a byte-addressed register port and a byte-level bus engine.
 */
package iap_pkg;

    localparam logic [7:0] OFS_SLAVE_ADDR = 8'h08;
    localparam logic [7:0] OFS_DATA_CMD = 8'h10;
    localparam logic [7:0] OFS_DATA_CMD_HI = 8'h11;

    localparam int SAR_W = 10;
    localparam int SAR7_W = 7;
    localparam logic [SAR_W-1:0] SAR_RESET = 10'h055;

    localparam int DAT_W = 8;
    localparam int POS_CMD = 8;
    localparam int POS_STOP = 9;
    localparam int POS_RESTART = 10;
    localparam int POS_FIRST = 11;

    localparam bit EMPTY_FIFO_HOLD_OPTION = 1'b1;
    localparam bit FIRST_BYTE_STATUS_OPTION = 1'b1;

    localparam int FIFO_DEPTH = 16;
    localparam int TX_W = 11;
    localparam int RX_W = 9;

    typedef enum logic [1:0] {
        COND_NONE,
        COND_START,
        COND_RESTART,
        COND_STOP_START
    } iap_cond_e;

endpackage

/* design/iap_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and registered flags.
 * Assumes DEPTH is a power of two and both sides share clk.
 */
`timescale 1ns/1ps
module iap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic in_ready_ff;
    logic out_valid_ff;
    logic push;
    logic pop;

    assign push = in_valid && in_ready_ff;
    assign pop = out_valid_ff && out_ready;
    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = mem[rd_ptr_ff];

    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - (AW+1)'(1);
        end
    end

    // storage has no reset, saving area
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            count_ff <= nxt_count;
            in_ready_ff <= nxt_count != (AW+1)'(DEPTH);
            out_valid_ff <= nxt_count != '0;
        end
    end

endmodule

/* design/iap_port.sv */
/*
 * Slave own-address register and data/command port of an I2C controller.
 * Host side: byte-addressed register port, reads answered one cycle later.
 * Bus side: a byte-level engine on the same clock takes commands and
 * returns received bytes and address phases; no synchronisers needed.
 */
`timescale 1ns/1ps
module iap_port
    import iap_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic interface_enable,
    input wire logic master_mode,
    input wire logic repeated_start_enable,
    input wire logic slave_ten_bit_select,
    output logic tx_fifo_ready,
    output logic rx_fifo_valid,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output iap_cond_e cmd_cond,
    output logic cmd_read,
    output logic cmd_stop,
    output logic [7:0] cmd_data,
    output logic hold_scl,
    output logic rx_ack,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic addr_valid,
    input wire logic addr_ten,
    input wire logic [9:0] addr_bits,
    output logic addr_match
);
    logic [SAR_W-1:0] sar_ff;
    logic [31:0] rdata_ff;
    logic [7:0] last_hi_ff;
    logic cmd_valid_ff;
    iap_cond_e cmd_cond_ff;
    logic cmd_read_ff;
    logic cmd_stop_ff;
    logic [DAT_W-1:0] cmd_data_ff;
    logic active_ff;
    logic dir_prev_ff;
    logic hold_scl_ff;
    logic rx_ack_ff;
    logic first_pending_ff;
    logic addr_match_ff;
    logic tx_out_valid;
    logic tx_out_ready;
    logic [TX_W-1:0] tx_in_data;
    logic [TX_W-1:0] tx_out_data;
    logic rx_out_valid;
    logic rx_out_ready;
    logic [RX_W-1:0] rx_in_data;
    logic [RX_W-1:0] rx_out_data;
    logic wr_sar;
    logic wr_data;
    logic take;
    logic head_read;
    logic head_stop;
    logic head_restart;
    logic first_bit;
    iap_cond_e nxt_cond;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    assign wr_sar = reg_wr && (reg_addr == OFS_SLAVE_ADDR);
    assign wr_data = reg_wr && (reg_addr == OFS_DATA_CMD);
    assign rx_out_ready = reg_rd && (reg_addr == OFS_DATA_CMD);
    assign head_read = tx_out_data[POS_CMD];
    assign head_stop = tx_out_data[POS_STOP];
    assign head_restart = tx_out_data[POS_RESTART];
    assign tx_out_ready = !cmd_valid_ff || cmd_ready;
    assign take = tx_out_valid && tx_out_ready;
    assign rx_in_data = {first_pending_ff, rx_data};
    assign first_bit = rx_out_data[DAT_W] & FIRST_BYTE_STATUS_OPTION;

    assign reg_rdata = rdata_ff;
    assign cmd_valid = cmd_valid_ff;
    assign cmd_cond = cmd_cond_ff;
    assign cmd_read = cmd_read_ff;
    assign cmd_stop = cmd_stop_ff;
    assign cmd_data = cmd_data_ff;
    assign hold_scl = hold_scl_ff;
    assign rx_ack = rx_ack_ff;
    assign addr_match = addr_match_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sar_ff <= SAR_RESET;
        end else if (wr_sar && !interface_enable) begin
            sar_ff <= reg_wdata[SAR_W-1:0];
        end
    end

    // reserved addresses are not filtered, software must avoid them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_match_ff <= 1'b0;
        end else if (addr_valid) begin
            if (slave_ten_bit_select) begin
                addr_match_ff <= addr_ten && (addr_bits == sar_ff);
            end else begin
                addr_match_ff <= !addr_ten && (addr_bits[SAR7_W-1:0] == sar_ff[SAR7_W-1:0]);
            end
        end
    end

    always_comb begin
        tx_in_data = reg_wdata[TX_W-1:0];
        if (!EMPTY_FIFO_HOLD_OPTION) begin
            tx_in_data[POS_RESTART:POS_STOP] = 2'h0;
        end
        if (reg_wdata[POS_CMD]) begin
            tx_in_data[DAT_W-1:0] = '0;
        end
    end

    iap_fifo #(.WIDTH(TX_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(wr_data),
        .in_ready(tx_fifo_ready),
        .in_data(tx_in_data),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data)
    );

    iap_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_in_data),
        .out_valid(rx_fifo_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_data)
    );
    assign rx_out_valid = rx_fifo_valid;

    // restart request lives in the queued entry, so it never outlives its command
    always_comb begin
        if (!master_mode) begin
            nxt_cond = COND_NONE;
        end else if (!active_ff) begin
            nxt_cond = COND_START;
        end else if (head_restart || (head_read != dir_prev_ff)) begin
            nxt_cond = repeated_start_enable ? COND_RESTART : COND_STOP_START;
        end else begin
            nxt_cond = COND_NONE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_valid_ff <= 1'b0;
            cmd_cond_ff <= COND_NONE;
            cmd_read_ff <= 1'b0;
            cmd_stop_ff <= 1'b0;
            cmd_data_ff <= '0;
        end else if (tx_out_ready) begin
            cmd_valid_ff <= tx_out_valid;
            if (tx_out_valid) begin
                cmd_cond_ff <= nxt_cond;
                cmd_read_ff <= master_mode && head_read;
                cmd_stop_ff <= head_stop;
                cmd_data_ff <= tx_out_data[DAT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_ff <= 1'b0;
            dir_prev_ff <= 1'b0;
        end else begin
            if (!interface_enable || !master_mode) begin
                active_ff <= 1'b0;
            end else if (take) begin
                active_ff <= !head_stop;
            end
            if (take) begin
                dir_prev_ff <= head_read;
            end
        end
    end

    // master stalls the bus rather than inventing a stop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_scl_ff <= 1'b0;
        end else begin
            hold_scl_ff <= EMPTY_FIFO_HOLD_OPTION && master_mode && active_ff && !tx_out_valid && !cmd_valid_ff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_ack_ff <= 1'b0;
        end else begin
            rx_ack_ff <= master_mode ? (cmd_valid_ff && cmd_read_ff) : rx_ready;
        end
    end

    // a new address phase wins over the clear from a byte pushed in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            first_pending_ff <= 1'b0;
        end else if (addr_valid || (take && nxt_cond != COND_NONE)) begin
            first_pending_ff <= 1'b1;
        end else if (rx_valid && rx_ready) begin
            first_pending_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= '0;
            last_hi_ff <= '0;
        end else begin
            if (reg_rd && reg_addr == OFS_SLAVE_ADDR) begin
                rdata_ff <= {22'h0, sar_ff};
            end else if (rx_out_ready) begin
                rdata_ff <= rx_out_valid ? {20'h0, first_bit, 3'h0, rx_out_data[DAT_W-1:0]} : '0;
            end else if (reg_rd && reg_addr == OFS_DATA_CMD_HI) begin
                rdata_ff <= {24'h0, last_hi_ff};
            end else begin
                rdata_ff <= '0;
            end
            if (rx_out_ready && rx_out_valid) begin
                last_hi_ff <= {4'h0, first_bit, 3'h0};
            end
        end
    end

    sequence s_first_byte;
        addr_valid ##[1:4] (rx_valid && rx_ready && !addr_valid && !take);
    endsequence

    sequence s_active_take;
        take && master_mode && active_ff && interface_enable;
    endsequence

    AST_SAR_LOCKED: assert property (interface_enable |=> $stable(sar_ff))
        else $error("slave address changed while enabled");
    AST_SAR_WRITE: assert property (wr_sar && !interface_enable |=> sar_ff == $past(reg_wdata[SAR_W-1:0]))
        else $error("slave address write lost");
    AST_MATCH7: assert property (addr_valid && !slave_ten_bit_select && !addr_ten
            && addr_bits[SAR7_W-1:0] == sar_ff[SAR7_W-1:0] |=> addr_match)
        else $error("seven bit address not matched");
    AST_MATCH10: assert property (addr_valid && slave_ten_bit_select
            && !(addr_ten && addr_bits == sar_ff) |=> !addr_match)
        else $error("ten bit address falsely matched");
    AST_RESTART_FORCED: assert property (s_active_take ##0 (head_restart && repeated_start_enable)
            |=> cmd_cond == COND_RESTART)
        else $error("restart bit did not force repeated start");
    AST_SAME_DIR: assert property (s_active_take ##0 (!head_restart && head_read == dir_prev_ff)
            |=> cmd_cond == COND_NONE)
        else $error("unneeded start condition issued");
    AST_STOP_START: assert property (s_active_take ##0 ((head_restart || head_read != dir_prev_ff)
            && !repeated_start_enable) |=> cmd_cond == COND_STOP_START)
        else $error("stop then start not issued");
    AST_FIRST_SET: assert property (addr_valid |=> first_pending_ff)
        else $error("first byte flag not armed");
    AST_FIRST_CLEAR: assert property (s_first_byte |=> !first_pending_ff)
        else $error("first byte flag not cleared");
    AST_READ_POP: assert property (rx_out_ready && rx_out_valid
            |=> reg_rdata[7:0] == $past(rx_out_data[7:0]) && reg_rdata[10:8] == 3'h0 && reg_rdata[31:12] == '0)
        else $error("read data wrong");
    AST_STOP_NO_HOLD: assert property (take && master_mode && head_stop && interface_enable |=> ##1 !hold_scl)
        else $error("clock held after stop command");
    AST_READ_DATA: assert property (take && head_read && master_mode |=> cmd_read && cmd_data == 8'h00)
        else $error("read command carried data");
    AST_NO_ACK: assert property (master_mode && !cmd_valid |=> !rx_ack)
        else $error("ack without pending read");

endmodule

/* verification/iap_engine_model.sv */
/*
 * Behavioural byte-level bus engine facing the port block: takes commands,
 * logs them, pushes address phases and received bytes on request.
 * Assumes it shares clk with the block; the bench steers stalls and traffic.
 */
`timescale 1ns/1ps
module iap_engine_model
    import iap_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire iap_cond_e cmd_cond,
    input wire logic cmd_read,
    input wire logic cmd_stop,
    input wire logic [7:0] cmd_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic addr_valid,
    output logic addr_ten,
    output logic [9:0] addr_bits
);
    logic [11:0] log_q[$];

    // stall models a slow bus: commands wait in the block
    assign cmd_ready = !stall;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        addr_valid = 1'b0;
        addr_ten = 1'b0;
        addr_bits = 10'h000;
    end

    always @(posedge clk) begin
        if (cmd_valid && cmd_ready) begin
            log_q.push_back({cmd_cond, cmd_read, cmd_stop, cmd_data});
        end
    end

    // idle lines show inverted values, not the stale ones
    task automatic send_addr(input logic ten, input logic [9:0] bits);
        @(posedge clk);
        #1;
        addr_valid = 1'b1;
        addr_ten = ten;
        addr_bits = bits;
        @(posedge clk);
        #1;
        addr_valid = 1'b0;
        addr_ten = ~ten;
        addr_bits = ~bits;
    endtask

    task automatic send_byte(input logic [7:0] d);
        @(posedge clk);
        #1;
        rx_valid = 1'b1;
        rx_data = d;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~d;
    endtask
endmodule

/* verification/iap_port_tb.sv */
/*
 * Self-checking bench for the address and data/command port block.
 * Assumes the engine model on the bus side and a 50 MHz clock.
 */
`timescale 1ns/1ps
module iap_port_tb
    import iap_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    logic interface_enable = 1'b0;
    logic master_mode = 1'b1;
    logic repeated_start_enable = 1'b1;
    logic slave_ten_bit_select = 1'b0;
    logic stall = 1'b1;
    logic tx_fifo_ready, rx_fifo_valid, cmd_valid, cmd_ready, cmd_read, cmd_stop, hold_scl;
    logic rx_ack, rx_valid, rx_ready, addr_valid, addr_ten, addr_match;
    iap_cond_e cmd_cond;
    logic [7:0] cmd_data, rx_data;
    logic [9:0] addr_bits;
    int num_errors = 0;
    int check_count = 0;

    always #10 clk = ~clk;

    iap_port uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interface_enable(interface_enable),
        .master_mode(master_mode), .repeated_start_enable(repeated_start_enable),
        .slave_ten_bit_select(slave_ten_bit_select), .tx_fifo_ready(tx_fifo_ready),
        .rx_fifo_valid(rx_fifo_valid), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_cond(cmd_cond),
        .cmd_read(cmd_read), .cmd_stop(cmd_stop), .cmd_data(cmd_data), .hold_scl(hold_scl), .rx_ack(rx_ack),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .addr_valid(addr_valid),
        .addr_ten(addr_ten), .addr_bits(addr_bits), .addr_match(addr_match));

    iap_engine_model eng (.clk(clk), .stall(stall), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_cond(cmd_cond), .cmd_read(cmd_read), .cmd_stop(cmd_stop), .cmd_data(cmd_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .addr_valid(addr_valid), .addr_ten(addr_ten),
        .addr_bits(addr_bits));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // release the engine until n commands are logged; bounded
    task automatic drain(input int n);
        stall = 1'b0;
        for (int i = 0; i < 60 && eng.log_q.size() < n; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        stall = 1'b1;
        check("cmd count", 32'(eng.log_q.size()), 32'(n));
        if (eng.log_q.size() != n) finish_test();
    endtask

    task automatic s_sar;
        logic [31:0] d;
        reg_read(OFS_SLAVE_ADDR, d);
        check("sar reset", d, 32'(SAR_RESET));
        reg_write(OFS_SLAVE_ADDR, 32'hfffffc23);
        reg_read(OFS_SLAVE_ADDR, d);
        check("sar width", d, 32'h00000023);
        reg_write(OFS_SLAVE_ADDR, 32'h00000123);
        reg_read(OFS_SLAVE_ADDR, d);
        check("sar write", d, 32'h00000123);
        interface_enable = 1'b1;
        reg_write(OFS_SLAVE_ADDR, 32'h000002aa);
        reg_read(OFS_SLAVE_ADDR, d);
        check("sar locked", d, 32'h00000123);
    endtask

    // {ten select, ten-bit phase, expected match, address}
    task automatic s_addr;
        logic [12:0] t [7];
        t = '{13'h0423, 13'h04a3, 13'h0024, 13'h0923, 13'h1d23, 13'h1922, 13'h1023};
        for (int i = 0; i < 7; i++) begin
            slave_ten_bit_select = t[i][12];
            eng.send_addr(t[i][11], t[i][9:0]);
            check("addr match", 32'(addr_match), 32'(t[i][10]));
        end
        slave_ten_bit_select = 1'b0;
    endtask

    // expected log entry: {cond, read, stop, data}
    task automatic s_cmds;
        logic [11:0] cw [11];
        logic [11:0] ex [11];
        cw = '{12'h0a5, 12'h03c, 12'h1ff, 12'h5ff, 12'h100, 12'h300, 12'h077, 12'h411, 12'h100, 12'h000, 12'h1ab};
        ex = '{12'h4a5, 12'h03c, 12'ha00, 12'ha00, 12'h200, 12'h300, 12'h477, 12'hc11, 12'he00, 12'hc00, 12'h000};
        eng.log_q.delete();
        check("hold idle", 32'(hold_scl), 32'h00000000);
        for (int i = 0; i < 7; i++) reg_write(OFS_DATA_CMD, {20'h00000, cw[i]});
        drain(7);
        repeated_start_enable = 1'b0;
        for (int i = 7; i < 10; i++) reg_write(OFS_DATA_CMD, {20'h00000, cw[i]});
        drain(10);
        check("hold clock", 32'(hold_scl), 32'h00000001);
        master_mode = 1'b0;
        reg_write(OFS_DATA_CMD, {20'h00000, cw[10]});
        drain(11);
        master_mode = 1'b1;
        for (int i = 0; i < 11; i++) check("command", 32'(eng.log_q[i]), 32'(ex[i]));
    endtask

    // fill while the engine stalls; a write when full is dropped
    task automatic s_fill;
        int n = 0;
        eng.log_q.delete();
        while (tx_fifo_ready === 1'b1 && n < 20) begin
            reg_write(OFS_DATA_CMD, 32'(n));
            n++;
        end
        // sixteen in the FIFO plus one parked in the command stage
        check("fifo full", 32'(n), 32'(FIFO_DEPTH + 1));
        reg_write(OFS_DATA_CMD, 32'h000000ee);
        drain(n);
        for (int i = 0; i < n; i++) check("fifo order", 32'(eng.log_q[i][7:0]), 32'(i[7:0]));
    endtask

    task automatic s_rx;
        logic [31:0] d;
        eng.log_q.delete();
        reg_write(OFS_DATA_CMD, 32'h00000100);
        repeat (3) @(posedge clk);
        #1;
        check("ack read queued", 32'(rx_ack), 32'h00000001);
        drain(1);
        check("ack none queued", 32'(rx_ack), 32'h00000000);
        master_mode = 1'b0;
        eng.send_addr(1'b0, 10'h023);
        check("ack slave", 32'(rx_ack), 32'h00000001);
        check("hold slave", 32'(hold_scl), 32'h00000000);
        check("rx ready", 32'(rx_ready), 32'h00000001);
        eng.send_byte(8'h11);
        eng.send_byte(8'h22);
        reg_read(OFS_DATA_CMD, d);
        check("rx first", d, 32'h00000811);
        reg_read(OFS_DATA_CMD_HI, d);
        check("rx flag first", d, 32'h00000008);
        reg_read(OFS_DATA_CMD, d);
        check("rx next", d, 32'h00000022);
        reg_read(OFS_DATA_CMD_HI, d);
        check("rx flag next", d, 32'h00000000);
        reg_read(OFS_DATA_CMD, d);
        check("rx empty", d, 32'h00000000);
        check("rx drained", 32'(rx_fifo_valid), 32'h00000000);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge clk);
        s_sar();
        s_addr();
        s_cmds();
        s_fill();
        s_rx();
        finish_test();
    end
endmodule
